// *** rtl/acr_pkg.sv ***
/*
  Package for the converter configuration register bank: byte addresses,
  field positions, reset values, code enumerations and the decoded
  analog control bundle.
  Assumes an APB slave with 32-bit data and one word per register.
*/
package acr_pkg;

  // Each register takes one aligned word, so its byte address is four
  // times its index.
  localparam logic [7:0] ACR_IDX_STATUS_CHECKS = 8'h02;
  localparam logic [7:0] ACR_IDX_ROUTING_OUTPUT = 8'h03;
  localparam logic [7:0] ACR_ADDR_STATUS_CHECKS =
    {ACR_IDX_STATUS_CHECKS[5:0], 2'b00};
  localparam logic [7:0] ACR_ADDR_ROUTING_OUTPUT =
    {ACR_IDX_ROUTING_OUTPUT[5:0], 2'b00};
  localparam logic [7:0] ACR_ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ACR_ADDR_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] ACR_ADDR_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] ACR_ADDR_COUNTER = 8'h2c;

  localparam logic [7:0] ACR_RESET_STATUS_CHECKS = 8'h00;
  localparam logic [7:0] ACR_RESET_ROUTING_OUTPUT = 8'h00;

  localparam int ACR_POS_READY = 7;
  localparam int ACR_POS_COUNT_EN = 6;
  localparam int ACR_POS_CHECK_HI = 5;
  localparam int ACR_POS_CHECK_LO = 4;
  localparam int ACR_POS_BURNOUT = 3;
  localparam int ACR_POS_CURRENT_HI = 2;
  localparam int ACR_POS_CURRENT_LO = 0;
  localparam int ACR_POS_ROUTE1_HI = 7;
  localparam int ACR_POS_ROUTE1_LO = 5;
  localparam int ACR_POS_ROUTE2_HI = 4;
  localparam int ACR_POS_ROUTE2_LO = 2;
  localparam int ACR_POS_RSVD = 1;
  localparam int ACR_POS_PUSH = 0;

  localparam logic [7:0] ACR_WMASK_STATUS_CHECKS = 8'h7f;
  localparam logic [7:0] ACR_WMASK_ROUTING_OUTPUT = 8'hfd;

  localparam int ACR_IRQ_READY = 0;
  localparam int ACR_IRQ_OVERRUN = 1;
  localparam logic [1:0] ACR_RESET_IRQ = 2'h0;
  localparam logic [15:0] ACR_RESET_COUNT = 16'h0000;

  typedef enum logic [1:0]
  {
    ACR_CHECK_OFF = 2'b00,
    ACR_CHECK_INVERTED = 2'b01,
    ACR_CHECK_CRC16 = 2'b10,
    ACR_CHECK_RSVD = 2'b11
  } acr_check_t;

  typedef enum logic [2:0]
  {
    ACR_ROUTE_OFF = 3'b000,
    ACR_ROUTE_AIN_ZERO = 3'b001,
    ACR_ROUTE_AIN_ONE = 3'b010,
    ACR_ROUTE_AIN_TWO = 3'b011,
    ACR_ROUTE_AIN_THREE = 3'b100,
    ACR_ROUTE_REF_POS = 3'b101,
    ACR_ROUTE_REF_NEG = 3'b110,
    ACR_ROUTE_RSVD = 3'b111
  } acr_route_t;

  // One-hot route selects: bit 0 to 3 analog inputs, 4 ref pos, 5 ref neg.
  typedef struct packed
  {
    logic count_enable;
    logic check_inverted;
    logic check_crc16;
    logic burnout_on;
    logic [2:0] current_code;
    logic [5:0] first_route;
    logic [5:0] second_route;
    logic push_mode;
  } acr_ctrl_t;

endpackage

// *** rtl/acr_regs.sv ***
/*
  Configuration register bank of the converter: the status/check register
  and the current routing/output register, an interrupt group and a
  conversion counter, all behind an APB slave.
  Assumes conversion events and data-read strobes come from logic on pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module acr_regs
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic result_new,
  input wire logic result_read,
  output acr_pkg::acr_ctrl_t ctrl,
  output logic irq
);

  function automatic logic [5:0] route_decode(input logic [2:0] code);
    logic [5:0] sel;
    sel = 6'h00;
    unique case (code)
      acr_pkg::ACR_ROUTE_AIN_ZERO: sel = 6'h01;
      acr_pkg::ACR_ROUTE_AIN_ONE: sel = 6'h02;
      acr_pkg::ACR_ROUTE_AIN_TWO: sel = 6'h04;
      acr_pkg::ACR_ROUTE_AIN_THREE: sel = 6'h08;
      acr_pkg::ACR_ROUTE_REF_POS: sel = 6'h10;
      acr_pkg::ACR_ROUTE_REF_NEG: sel = 6'h20;
      // Off and the reserved code both leave the source unconnected.
      acr_pkg::ACR_ROUTE_OFF: sel = 6'h00;
      acr_pkg::ACR_ROUTE_RSVD: sel = 6'h00;
    endcase
    return sel;
  endfunction

  logic [7:0] status_checks_q;
  logic [7:0] status_checks_d;
  logic [7:0] routing_output_q;
  logic [7:0] routing_output_d;
  logic ready_q;
  logic ready_d;
  logic [1:0] irq_status_q;
  logic [1:0] irq_status_d;
  logic [1:0] irq_enable_q;
  logic [1:0] irq_enable_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;

  wire logic access = psel && penable;
  wire logic wr = access && pwrite && pstrb[0];
  wire logic rd = access && !pwrite;
  wire logic hit_status = paddr == acr_pkg::ACR_ADDR_STATUS_CHECKS;
  wire logic hit_routing = paddr == acr_pkg::ACR_ADDR_ROUTING_OUTPUT;
  wire logic hit_irq_status = paddr == acr_pkg::ACR_ADDR_IRQ_STATUS;
  wire logic hit_irq_enable = paddr == acr_pkg::ACR_ADDR_IRQ_ENABLE;
  wire logic hit_irq_clear = paddr == acr_pkg::ACR_ADDR_IRQ_CLEAR;
  wire logic hit_count = paddr == acr_pkg::ACR_ADDR_COUNTER;
  wire logic mapped = hit_status || hit_routing || hit_irq_status
    || hit_irq_enable || hit_irq_clear || hit_count;
  wire logic [7:0] wbyte = pwdata[7:0];

  // Only writable fields are taken; the flag and reserved bit stay put.
  assign status_checks_d = (wr && hit_status)
    ? (wbyte & acr_pkg::ACR_WMASK_STATUS_CHECKS)
    : status_checks_q;
  assign routing_output_d = (wr && hit_routing)
    ? (wbyte & acr_pkg::ACR_WMASK_ROUTING_OUTPUT)
    : routing_output_q;

  // A new result in the same cycle as a data read keeps the flag set.
  assign ready_d = result_new ? 1'b1
    : (result_read ? 1'b0 : ready_q);

  wire logic overrun = result_new && ready_q && !result_read;
  wire logic [1:0] irq_events = {overrun, result_new};
  wire logic [1:0] irq_clear = (wr && hit_irq_clear) ? pwdata[1:0] : 2'b00;
  assign irq_status_d = irq_events | (irq_status_q & ~irq_clear);
  assign irq_enable_d = (wr && hit_irq_enable) ? pwdata[1:0] : irq_enable_q;

  wire logic count_en = status_checks_q[acr_pkg::ACR_POS_COUNT_EN];
  assign count_d = (count_en && result_new) ? 16'(count_q + 16'h0001)
    : count_q;

  wire logic [7:0] status_view = {ready_q,
    status_checks_q[acr_pkg::ACR_POS_COUNT_EN:0]};
  wire logic [7:0] routing_view = routing_output_q;
  assign prdata_d =
    hit_status ? {24'h00_0000, status_view}
    : hit_routing ? {24'h00_0000, routing_view}
    : hit_irq_status ? {30'h000_0000, irq_status_q}
    : hit_irq_enable ? {30'h000_0000, irq_enable_q}
    : hit_count ? {16'h0000, count_q}
    : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_checks_q <= acr_pkg::ACR_RESET_STATUS_CHECKS;
      routing_output_q <= acr_pkg::ACR_RESET_ROUTING_OUTPUT;
      ready_q <= 1'b0;
      irq_status_q <= acr_pkg::ACR_RESET_IRQ;
      irq_enable_q <= acr_pkg::ACR_RESET_IRQ;
      count_q <= acr_pkg::ACR_RESET_COUNT;
    end
    else
    begin
      status_checks_q <= status_checks_d;
      routing_output_q <= routing_output_d;
      ready_q <= ready_d;
      irq_status_q <= irq_status_d;
      irq_enable_q <= irq_enable_d;
      count_q <= count_d;
    end
  end

  // Read data is registered in the setup cycle so the access phase is one
  // cycle with pready high; this keeps the read path off the APB timing.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_q <= pwrite ? 32'h0000_0000 : prdata_d;
      pslverr_q <= !mapped;
    end
  end

  assign prdata = rd ? prdata_q : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = access && pslverr_q;
  assign irq = |(irq_status_q & irq_enable_q);

  wire logic [1:0] check_sel =
    status_checks_q[acr_pkg::ACR_POS_CHECK_HI:acr_pkg::ACR_POS_CHECK_LO];

  always_comb
  begin
    ctrl.count_enable = count_en;
    // The reserved check code enables neither check.
    ctrl.check_inverted = check_sel == acr_pkg::ACR_CHECK_INVERTED;
    ctrl.check_crc16 = check_sel == acr_pkg::ACR_CHECK_CRC16;
    ctrl.burnout_on = status_checks_q[acr_pkg::ACR_POS_BURNOUT];
    ctrl.current_code = status_checks_q[acr_pkg::ACR_POS_CURRENT_HI:
      acr_pkg::ACR_POS_CURRENT_LO];
    ctrl.first_route = route_decode(routing_output_q[
      acr_pkg::ACR_POS_ROUTE1_HI:acr_pkg::ACR_POS_ROUTE1_LO]);
    ctrl.second_route = route_decode(routing_output_q[
      acr_pkg::ACR_POS_ROUTE2_HI:acr_pkg::ACR_POS_ROUTE2_LO]);
    ctrl.push_mode = routing_output_q[acr_pkg::ACR_POS_PUSH];
  end

endmodule

`default_nettype wire

// *** bench/acr_conv_model.sv ***
/* Conversion-side model: pulses result_new and result_read on request,
   alone or both in one cycle.
   Assumes the caller enters a task just after a rising pclk edge. */
`timescale 1ns/1ps
`default_nettype none
module acr_conv_model
(
  input wire logic pclk,
  output logic result_new = 1'b0,
  output logic result_read = 1'b0
);
  task convert;
    @(posedge pclk) result_new <= 1'b1;
    @(posedge pclk) result_new <= 1'b0;
  endtask
  task take;
    @(posedge pclk) result_read <= 1'b1;
    @(posedge pclk) result_read <= 1'b0;
  endtask
  task both;
    @(posedge pclk)
    begin
      result_new <= 1'b1;
      result_read <= 1'b1;
    end
    @(posedge pclk)
    begin
      result_new <= 1'b0;
      result_read <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** bench/acr_regs_checker.sv ***
/* Assertions on the acr_regs ports.
   Assumes a bind to acr_regs and an access phase of one cycle. */
`timescale 1ns/1ps
`default_nettype none
module acr_regs_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic result_new,
  input wire logic result_read,
  input wire acr_pkg::acr_ctrl_t ctrl
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  function automatic logic [5:0] oh(input logic [2:0] c);
    oh = (c == 3'h0 || c == 3'h7) ? 6'h00 : 6'h01 << (c - 3'h1);
  endfunction
  sequence wr(a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence rs;
    psel && !penable && !pwrite && paddr == 8'h08;
  endsequence
  chk_reset_zero: assert property
    ($rose(presetn) |-> ctrl == '0) else $error("ctrl not zero");
  chk_flag_set: assert property (result_new ##1 rs |=> prdata[7])
    else $error("flag not set");
  chk_flag_clear: assert property
    (result_read && !result_new ##1 rs |=> !prdata[7]) else $error("flag kept");
  chk_count_write: assert property (wr(8'h08) |=>
    ctrl.count_enable == $past(pwdata[6])) else $error("count enable");
  chk_check_decode: assert property (wr(8'h08) |=>
    {ctrl.check_crc16, ctrl.check_inverted} == ($past(pwdata[5:4]) == 2'h3 ?
    2'h0 : $past(pwdata[5:4]))) else $error("check select");
  chk_source_current: assert property (wr(8'h08) |=>
    {ctrl.burnout_on, ctrl.current_code} == $past(pwdata[3:0]))
    else $error("current setting");
  chk_route_decode: assert property (wr(8'h0c) |=>
    ctrl.first_route == oh($past(pwdata[7:5])) &&
    ctrl.second_route == oh($past(pwdata[4:2]))) else $error("routing");
  chk_push_write: assert property (wr(8'h0c) |=>
    ctrl.push_mode == $past(pwdata[0])) else $error("push mode");
endmodule
bind acr_regs acr_regs_checker u_acr_regs_checker
(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .result_new(result_new),
  .result_read(result_read),
  .ctrl(ctrl)
);
`default_nettype wire

// *** bench/test_acr_regs.sv ***
/* Bench for acr_regs: APB register traffic and conversion events.
   Assumes the conversion model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_acr_regs;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, result_new, result_read, err;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, e;
  logic [2:0] v;
  acr_pkg::acr_ctrl_t ctrl;
  int failures = 0, checked = 0;
  always #10 pclk = ~pclk;
  acr_regs u_acr_regs
  (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .result_new(result_new),
    .result_read(result_read),
    .ctrl(ctrl),
    .irq(irq)
  );
  acr_conv_model u_acr_conv_model
  (
    .pclk(pclk),
    .result_new(result_new),
    .result_read(result_read)
  );
  function automatic logic [5:0] oh(input logic [2:0] c);
    oh = (c == 3'h0 || c == 3'h7) ? 6'h00 : 6'h01 << (c - 3'h1);
  endfunction
  task report_and_stop;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      failures++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1)
    begin
      failures++;
      report_and_stop;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never drives psel twice in one step.
    @(posedge pclk);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, {24'h00_0000, x});
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h08, 8'h00);
    chk(32'(err), 32'h0000_0000);
    rdc(8'h0c, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      v = 3'(c);
      apb(1'b1, 8'h08, {24'h00_0000, 2'h3, v[1:0], v[0], v});
      apb(1'b1, 8'h0c, {24'h00_0000, v, v ^ 3'h5, 1'b1, v[0]});
      rdc(8'h08, {2'h1, v[1:0], v[0], v});
      rdc(8'h0c, {v, v ^ 3'h5, 1'b0, v[0]});
      e = 32'({1'b1, v[1:0] == 2'h1, v[1:0] == 2'h2, v[0], v, oh(v),
        oh(v ^ 3'h5), v[0]});
      chk(32'(ctrl), e);
    end
    apb(1'b1, 8'h24, 32'h0000_0001);
    u_acr_conv_model.convert();
    rdc(8'h08, 8'hff);
    chk(32'(irq), 32'h0000_0001);
    u_acr_conv_model.take();
    rdc(8'h08, 8'h7f);
    apb(1'b1, 8'h28, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, 8'h24, 32'h0000_0000);
    u_acr_conv_model.convert();
    rdc(8'h20, 8'h01);
    chk(32'(irq), 32'h0000_0000);
    rdc(8'h2c, 8'h02);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    // A result while the flag is still up and unread counts as an overrun.
    apb(1'b1, 8'h24, 32'h0000_0002);
    u_acr_conv_model.convert();
    rdc(8'h20, 8'h03);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, 8'h20, 32'h0000_0000);
    rdc(8'h20, 8'h03);
    // The clear meets both events at one edge and must lose to them.
    fork
      u_acr_conv_model.convert();
      apb(1'b1, 8'h28, 32'h0000_0003);
    join
    rdc(8'h20, 8'h03);
    apb(1'b1, 8'h28, 32'h0000_0003);
    rdc(8'h20, 8'h00);
    chk(32'(irq), 32'h0000_0000);
    // A new result in the cycle of a data read leaves the flag set.
    u_acr_conv_model.both();
    rdc(8'h08, 8'hff);
    rdc(8'h20, 8'h01);
    rdc(8'h2c, 8'h05);
    apb(1'b1, 8'h08, 32'h0000_003f);
    u_acr_conv_model.convert();
    rdc(8'h2c, 8'h05);
    rdc(8'h08, 8'hbf);
    chk(32'(ctrl.count_enable), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0001);
    // A write with the low byte strobe off must leave the register alone.
    pstrb <= 4'he;
    apb(1'b1, 8'h0c, 32'h0000_0000);
    pstrb <= 4'hf;
    rdc(8'h0c, 8'he9);
    // A second reset in mid-run must clear all that the run has set.
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h08, 8'h00);
    rdc(8'h0c, 8'h00);
    rdc(8'h2c, 8'h00);
    chk(32'(ctrl), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    report_and_stop;
  end
endmodule
`default_nettype wire
